// *** src/ssel_pkg.sv ***
// Package for the start signal selection block: setting codes, timing, carriers.
// Assumes a single system clock; all users import the whole package.
`default_nettype none
package ssel_pkg;
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned SECOND_S = 1;
  localparam int unsigned TICKS_PER_SEC = SYS_CLK_HZ * SECOND_S;
  localparam logic [13:0] SM_DECEL_TWO_WIRE = 14'h270f;
  localparam logic [13:0] SM_DECEL_START_DIR = 14'h22b8;
  localparam logic [13:0] SM_TWO_WIRE_MAX = 14'h0064;
  localparam logic [13:0] SM_START_DIR_MIN = 14'h03e8;
  localparam logic [13:0] SM_START_DIR_MAX = 14'h044c;
  localparam logic [7:0] FUNC_HOLD_ENABLE = 8'h19;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned DELAY_W = 7;
  localparam int unsigned PRESC_W = 24;
  localparam int unsigned PIN_FWD = 0;
  localparam int unsigned PIN_REV = 1;
  localparam int unsigned PIN_SHUTOFF = 2;
  localparam int unsigned PIN_HOLD = 3;
  localparam int unsigned PIN_INCH = 4;
  localparam int unsigned PIN_TERM0 = 5;

  typedef struct packed {
    logic [13:0] stop_method_setting;
    logic [7:0] first_input_assign_setting;
    logic [7:0] second_input_assign_setting;
  } ssel_cfg_t;

  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic drive_en;
    logic decel;
    logic coast;
    logic held;
  } ssel_sts_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_COAST} ssel_state_t;
endpackage
`default_nettype wire

// *** src/ssel_top.sv ***
// Start signal selection: decodes start, direction and hold-enable pins into run and stop commands.
// Assumes pins are asynchronous to i_clk_sys and i_motor_stopped comes from logic on the same clock.
//
// Overview of operation
// - Settings 9999 or 0..100: forward input runs forward, reverse input runs reverse.
// - Settings 8888 or 1000..1100: forward input is run, reverse input selects direction.
// - Setting 0..100: coast once that many seconds pass after start removal.
// - Setting 1000..1100: coast after setting minus 1000 seconds following start removal.
// - Settings 9999 and 8888: start removal decelerates to a stop, no coast.
// - Two-wire decoding: both inputs off or both on while running decelerates to stop.
// - Forward function only via first assignment, reverse only via second assignment.
// - Active hold-enable turns on self-holding; start inputs become start triggers only, except the start-dir reverse input, which still selects direction.
// - In self-holding, a pulsed start input is latched and the drive starts.
// - One drop of hold-enable clears the latched start and decelerates to stop.
// - Hold-enable has its own pin; code 25 maps it to another terminal too.
// - While inching input is active, hold-enable is ignored.
// - Output shutoff stops output but keeps the latched self-hold state.
// - Start-dir: run off stops, run alone forward, both reverse; two-wire both stop.
// - Output shutoff while running cuts drive at once, motor coasts.
`default_nettype none
module ssel_top
  import ssel_pkg::*;
#(
  parameter int unsigned NTERM = 4,
  parameter int unsigned TICKS_SEC = TICKS_PER_SEC,
  parameter logic [7:0] FWD_CODE = 8'h00,
  parameter logic [7:0] REV_CODE = 8'h01
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_forward_start_input,
  input wire logic i_reverse_start_input,
  input wire logic i_output_shutoff_input,
  input wire logic i_hold_enable_input,
  input wire logic i_inching_input,
  input wire logic [NTERM-1:0] i_term,
  input wire logic [NTERM-1:0][7:0] i_term_assign,
  input wire ssel_cfg_t i_cfg,
  input wire logic i_motor_stopped,
  output var ssel_sts_t o_status
);
  localparam int unsigned NPIN = PIN_TERM0 + NTERM;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, filt_q;
  assign pin_raw = {i_term, i_inching_input, i_hold_enable_input, i_output_shutoff_input,
                    i_reverse_start_input, i_forward_start_input};

  // Three stages; a level is accepted only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          filt_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            filt_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  logic [NTERM-1:0] term_hold;
  generate
    for (g = 0; g < NTERM; g++) begin : g_map
      assign term_hold[g] = filt_q[PIN_TERM0+g] && (i_term_assign[g] == FUNC_HOLD_ENABLE);
    end
  endgenerate

  // Live start functions exist only on their own pins and their own assignment settings
  wire fwd_live = filt_q[PIN_FWD] && (i_cfg.first_input_assign_setting == FWD_CODE);
  wire rev_live = filt_q[PIN_REV] && (i_cfg.second_input_assign_setting == REV_CODE);
  wire shutoff = filt_q[PIN_SHUTOFF];
  wire hold_raw = filt_q[PIN_HOLD] || (|term_hold);
  wire hold_act = hold_raw && !filt_q[PIN_INCH];

  wire [13:0] sm = i_cfg.stop_method_setting;
  wire in_sd_range = (sm >= SM_START_DIR_MIN) && (sm <= SM_START_DIR_MAX);
  wire in_2w_range = (sm <= SM_TWO_WIRE_MAX);
  wire sd_mode = (sm == SM_DECEL_START_DIR) || in_sd_range;
  wire timed = in_2w_range || in_sd_range;
  wire [13:0] sm_off = sm - SM_START_DIR_MIN;
  wire [DELAY_W-1:0] delay_s = in_2w_range ? sm[DELAY_W-1:0] : sm_off[DELAY_W-1:0];

  // Self-hold latch: rising edge of a start input arms it, so a pulse on then off stays held
  logic fwd_prev_q, rev_prev_q, hfwd_q, hrev_q;
  wire fwd_rise = fwd_live && !fwd_prev_q;
  wire rev_rise = rev_live && !rev_prev_q;
  wire hfwd_d = !hold_act ? 1'b0 : (fwd_rise ? 1'b1 : ((rev_rise && !sd_mode) ? 1'b0 : hfwd_q));
  wire hrev_d = (!hold_act || sd_mode) ? 1'b0 : (rev_rise ? 1'b1 : (fwd_rise ? 1'b0 : hrev_q));

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      fwd_prev_q <= 1'b0;
      rev_prev_q <= 1'b0;
      hfwd_q <= 1'b0;
      hrev_q <= 1'b0;
    end else begin
      fwd_prev_q <= fwd_live;
      rev_prev_q <= rev_live;
      hfwd_q <= hfwd_d;
      hrev_q <= hrev_d;
    end
  end

  // In start-dir mode the reverse input keeps its direction role even while holding
  wire eff_f = hold_act ? (hfwd_q || fwd_live) : fwd_live;
  wire eff_r = (hold_act && !sd_mode) ? (hrev_q || rev_live) : rev_live;
  wire cmd_run = sd_mode ? eff_f : (eff_f ^ eff_r);
  wire cmd_rev = sd_mode ? eff_r : (eff_r && !eff_f);

  ssel_state_t st_q, st_d;
  logic timed_q, timed_d;
  logic [DELAY_W-1:0] sec_q, sec_d;
  logic [PRESC_W-1:0] presc_q;
  wire tick = (presc_q == PRESC_W'(TICKS_SEC - 1));
  wire [PRESC_W-1:0] presc_d = (st_q != ST_DECEL || tick) ? '0 : presc_q + 1'b1;

  always_comb begin
    st_d = st_q;
    timed_d = timed_q;
    sec_d = sec_q;
    unique case (st_q)
      ST_IDLE: begin
        if (cmd_run) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!cmd_run) begin
          timed_d = timed;
          sec_d = delay_s;
          st_d = (timed && delay_s == '0) ? ST_COAST : ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (cmd_run) begin
          st_d = ST_RUN;
        end else if (i_motor_stopped) begin
          st_d = ST_IDLE;
        end else if (timed_q && sec_q == '0) begin
          st_d = ST_COAST;
        end else if (tick && sec_q != '0) begin
          sec_d = sec_q - 1'b1;
        end
      end
      ST_COAST: begin
        if (cmd_run) begin
          st_d = ST_RUN;
        end else if (i_motor_stopped) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  ssel_sts_t sts_d;
  wire active_d = (st_d == ST_RUN) || (st_d == ST_DECEL);
  // Shutoff only gates the drive; the state machine and hold latch keep running beneath it
  assign sts_d.run_fwd = (st_d == ST_RUN) && !cmd_rev && !shutoff;
  assign sts_d.run_rev = (st_d == ST_RUN) && cmd_rev && !shutoff;
  assign sts_d.drive_en = active_d && !shutoff;
  assign sts_d.decel = (st_d == ST_DECEL) && !shutoff;
  assign sts_d.coast = (st_d == ST_COAST) || (shutoff && st_d != ST_IDLE);
  assign sts_d.held = hfwd_d || hrev_d;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_q <= ST_IDLE;
      timed_q <= 1'b0;
      sec_q <= '0;
      presc_q <= '0;
      o_status <= '0;
    end else begin
      st_q <= st_d;
      timed_q <= timed_d;
      sec_q <= sec_d;
      presc_q <= presc_d;
      o_status <= sts_d;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence s_running_2w;
    st_q == ST_RUN && !sd_mode && !hold_act && !shutoff;
  endsequence
  sequence s_running_sd;
    st_q == ST_RUN && sd_mode && !hold_act && !shutoff;
  endsequence

  property p_two_wire_fwd;
    s_running_2w and (fwd_live && !rev_live) |=> o_status.run_fwd && !o_status.run_rev;
  endproperty
  a_two_wire_fwd: assert property (p_two_wire_fwd) else $error("two-wire forward not driven");

  property p_start_dir_rev;
    s_running_sd and (fwd_live && rev_live) |=> o_status.run_rev && !o_status.run_fwd;
  endproperty
  a_start_dir_rev: assert property (p_start_dir_rev) else $error("start-dir reverse not driven");

  property p_timed_coast;
    st_q == ST_DECEL && timed_q && sec_q == '0 && !cmd_run && !i_motor_stopped |=> st_q == ST_COAST;
  endproperty
  a_timed_coast: assert property (p_timed_coast) else $error("timed stop did not coast");

  property p_delay_zero;
    st_q == ST_RUN && !cmd_run && timed && delay_s == '0 |=> st_q == ST_COAST && o_status.coast && !o_status.drive_en;
  endproperty
  a_delay_zero: assert property (p_delay_zero) else $error("zero delay did not coast at once");

  property p_decel_only;
    st_q == ST_DECEL && !timed_q && !cmd_run && !i_motor_stopped |=> st_q == ST_DECEL;
  endproperty
  a_decel_only: assert property (p_decel_only) else $error("decelerating stop left early");

  property p_both_stop;
    s_running_2w and (fwd_live && rev_live) |=> st_q != ST_RUN && !o_status.run_fwd && !o_status.run_rev;
  endproperty
  a_both_stop: assert property (p_both_stop) else $error("both inputs did not stop");

  property p_hold_latch;
    hold_act && fwd_rise && !rev_rise ##1 hold_act && !rev_rise |=> o_status.held && hfwd_q;
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("pulsed start not latched");

  property p_hold_clear;
    !hold_act |=> !hfwd_q && !hrev_q && !o_status.held;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("hold drop did not clear");

  property p_inch_ignore;
    filt_q[PIN_INCH] |=> !o_status.held && !hfwd_q && !hrev_q;
  endproperty
  a_inch_ignore: assert property (p_inch_ignore) else $error("hold honoured while inching");

  property p_shutoff_keep;
    shutoff && hold_act && hfwd_q && !rev_rise ##1 hold_act |-> hfwd_q;
  endproperty
  a_shutoff_keep: assert property (p_shutoff_keep) else $error("shutoff cleared held start");

  property p_shutoff_cut;
    shutoff |=> !o_status.drive_en && !o_status.run_fwd && !o_status.run_rev;
  endproperty
  a_shutoff_cut: assert property (p_shutoff_cut) else $error("shutoff did not cut drive");
endmodule
`default_nettype wire

// *** verification/ssel_switch_model.sv ***
// Switches or controller that drive the start, hold, inching and shutoff pins.
// Assumes the bench calls its tasks; pins change 1 ns after a rising clock edge.
`default_nettype none
module ssel_switch_model (
  input wire logic i_clk_sys,
  output logic o_fwd,
  output logic o_rev,
  output logic o_hold,
  output logic o_inch,
  output logic o_shutoff
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_fwd, o_rev, o_hold, o_inch, o_shutoff} = 5'h00;
  end
  task automatic set(input logic f, input logic r);
    @(posedge i_clk_sys) #1;
    o_fwd = f;
    o_rev = r;
  endtask
  task automatic aux(input logic h, input logic i, input logic s);
    @(posedge i_clk_sys) #1;
    {o_hold, o_inch, o_shutoff} = {h, i, s};
  endtask
  // Held well past the pin filter, then released once, as a push button does
  task automatic pulse(input logic f, input logic r);
    set(f, r);
    repeat (8) @(posedge i_clk_sys);
    set(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the start signal selection block.
// Assumes the switch model drives the pins; expected results are queued as mask and value notes.
`default_nettype none
module tb_top
  import ssel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TS = 20;
  localparam logic [5:0] M_FWD = 6'h20, M_REV = 6'h10, M_DRV = 6'h08, M_DEC = 6'h04, M_CST = 6'h02, M_HLD = 6'h01;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_motor_stopped = 1'b0;
  logic [3:0] i_term = 4'h0;
  logic [3:0][7:0] i_term_assign = 32'h0;
  ssel_cfg_t i_cfg;
  ssel_sts_t o_status;
  logic fwd, rev, hold, inch, shutoff;
  int n_errors = 0;
  int checks = 0;
  logic [5:0] q_mask[$];
  logic [5:0] q_exp[$];

  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  ssel_top #(.NTERM(4), .TICKS_SEC(TS)) i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_forward_start_input(fwd), .i_reverse_start_input(rev), .i_output_shutoff_input(shutoff),
    .i_hold_enable_input(hold), .i_inching_input(inch), .i_term(i_term), .i_term_assign(i_term_assign),
    .i_cfg(i_cfg), .i_motor_stopped(i_motor_stopped), .o_status(o_status));
  ssel_switch_model u_sw (.i_clk_sys(i_clk_sys), .o_fwd(fwd), .o_rev(rev), .o_hold(hold), .o_inch(inch),
    .o_shutoff(shutoff));

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic note(input logic [5:0] m, input logic [5:0] e);
    q_mask.push_back(m);
    q_exp.push_back(e);
  endtask
  // Bounded wait for the watcher to use up every note
  task automatic drain();
    for (int k = 0; k < 4000 && q_mask.size() > 0; k++) @(posedge i_clk_sys);
    if (q_mask.size() > 0) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, o_status, q_exp[0]);
      results();
    end
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic step(input logic f, input logic r, input logic [5:0] m, input logic [5:0] e);
    note(m, e);
    u_sw.set(f, r);
    drain();
  endtask
  task automatic stop_motor();
    note(M_DEC | M_CST | M_DRV, 6'h00);
    i_motor_stopped = 1'b1;
    drain();
    i_motor_stopped = 1'b0;
  endtask

  // A note is taken only when a bit under its mask changes, so unrelated fields may settle freely
  initial begin
    logic [5:0] prev;
    prev = 6'h00;
    forever begin
      @(negedge i_clk_sys);
      if (q_mask.size() > 0 && ((o_status ^ prev) & q_mask[0]) != 6'h00) begin
        chk(o_status & q_mask.pop_front(), q_exp.pop_front());
      end
      prev = o_status;
    end
  end

  initial begin
    int d;
    int n;
    i_cfg = {SM_DECEL_TWO_WIRE, 8'h00, 8'h01};
    void'($urandom(32'hd2a67ed8));
    repeat (20) @(posedge i_clk_sys);
    #1 i_reset_n = 1'b1;
    step(1'b1, 1'b0, M_FWD, M_FWD);
    step(1'b0, 1'b0, M_DEC, M_DEC);
    stop_motor();
    step(1'b0, 1'b1, M_REV, M_REV);
    step(1'b1, 1'b1, M_DEC, M_DEC);
    stop_motor();
    u_sw.set(1'b0, 1'b0);
    $display("test two_wire done");
    // Let released pins clear the filter before the decoding changes under them
    repeat (6) @(posedge i_clk_sys);
    #1;
    i_cfg.stop_method_setting = SM_DECEL_START_DIR;
    step(1'b1, 1'b0, M_FWD, M_FWD);
    step(1'b1, 1'b1, M_REV, M_REV);
    step(1'b0, 1'b1, M_DEC, M_DEC);
    stop_motor();
    repeat (10) @(negedge i_clk_sys);
    chk(o_status, 6'h00);
    u_sw.set(1'b0, 1'b0);
    $display("test start_dir done");
    repeat (6) @(posedge i_clk_sys);
    #1;
    for (int j = 0; j < 2; j++) begin
      d = $urandom % 6;
      i_cfg.stop_method_setting = 14'(j * 1000 + d);
      step(1'b1, 1'b0, M_FWD, M_FWD);
      note(M_CST, M_CST);
      u_sw.set(1'b0, 1'b0);
      n = 0;
      while (o_status.coast !== 1'b1 && n < 3000) begin
        @(negedge i_clk_sys);
        n++;
      end
      if (n >= 3000) begin
        n_errors++;
        $display("mismatch at %0t got %h expected %h", $time, o_status, M_CST);
        results();
      end
      chk({5'h00, n >= d * TS + 2 && n <= d * TS + 8}, 6'h01);
      chk(o_status & M_DRV, 6'h00);
      drain();
      stop_motor();
    end
    $display("test timed_coast done");
    i_cfg.stop_method_setting = SM_DECEL_TWO_WIRE;
    u_sw.aux(1'b1, 1'b0, 1'b0);
    note(M_HLD, M_HLD);
    u_sw.pulse(1'b1, 1'b0);
    drain();
    chk(o_status & (M_FWD | M_HLD), M_FWD | M_HLD);
    note(M_CST, M_CST);
    u_sw.aux(1'b1, 1'b0, 1'b1);
    drain();
    chk(o_status, M_CST | M_HLD);
    note(M_CST, 6'h00);
    u_sw.aux(1'b1, 1'b0, 1'b0);
    drain();
    note(M_REV, M_REV);
    u_sw.pulse(1'b0, 1'b1);
    drain();
    note(M_HLD, 6'h00);
    u_sw.aux(1'b1, 1'b1, 1'b0);
    drain();
    stop_motor();
    u_sw.aux(1'b1, 1'b0, 1'b0);
    note(M_HLD, M_HLD);
    u_sw.pulse(1'b1, 1'b0);
    drain();
    note(M_HLD, 6'h00);
    u_sw.aux(1'b0, 1'b0, 1'b0);
    drain();
    chk(o_status & M_DEC, M_DEC);
    stop_motor();
    $display("test self_hold done");
    i_term_assign[2] = FUNC_HOLD_ENABLE;
    i_term[2] = 1'b1;
    note(M_HLD, M_HLD);
    u_sw.pulse(1'b1, 1'b0);
    drain();
    i_reset_n = 1'b0;
    repeat (5) @(posedge i_clk_sys);
    #1 i_reset_n = 1'b1;
    @(negedge i_clk_sys);
    chk(o_status, 6'h00);
    i_term[2] = 1'b0;
    i_cfg.first_input_assign_setting = 8'h05;
    i_cfg.second_input_assign_setting = 8'h05;
    u_sw.set(1'b1, 1'b0);
    repeat (12) @(negedge i_clk_sys);
    chk(o_status, 6'h00);
    u_sw.set(1'b0, 1'b1);
    repeat (12) @(negedge i_clk_sys);
    chk(o_status, 6'h00);
    $display("test mapping done");
    results();
  end
endmodule
`default_nettype wire
